// File: rtl/usx_pkg.sv
// Package of register offsets, field positions and constants for the serial port.
package usx_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_TXSC = 4'h0;
  localparam logic [3:0] ADDR_RXSC = 4'h1;
  localparam logic [3:0] ADDR_TXBUF = 4'h2;
  localparam logic [3:0] ADDR_BAUD = 4'h3;
  localparam logic [3:0] ADDR_IFLAG = 4'h4;
  localparam logic [3:0] ADDR_IEN = 4'h5;
  localparam logic [3:0] ADDR_IPRI = 4'h6;
  localparam logic [3:0] ADDR_ISTAT = 4'h7;
  localparam logic [3:0] ADDR_ICLR = 4'h8;
  localparam logic [3:0] ADDR_IEVEN = 4'h9;
  localparam logic [3:0] ADDR_PINDIR = 4'hA;

  // ----------------------------------------
  // Transmit control fields
  // ----------------------------------------
  localparam int TX_CLKSRC = 7;
  localparam int TX_WIDTH = 6;
  localparam int TX_EN = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_SPEED = 2;
  localparam int TX_EMPTY = 1;
  localparam int TX_NINTH = 0;
  localparam logic [7:0] TXSC_RESET = 8'h02;
  localparam logic [7:0] TXSC_WMASK = 8'hF5;

  // ----------------------------------------
  // Receive control fields
  // ----------------------------------------
  localparam int RX_SERIAL_PORT_ENABLE = 7;
  localparam int RX_SINGLE_RECEIVE_ENABLE = 5;
  localparam int RX_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam logic [7:0] RXSC_RESET = 8'h00;
  localparam logic [7:0] RXSC_WMASK = 8'hF8;

  // ----------------------------------------
  // Interrupt flag, event and pin direction fields
  // ----------------------------------------
  localparam int IF_TX = 4;
  localparam int EV_TXLOAD = 0;
  localparam int EV_DONE = 1;
  localparam logic [7:0] PINDIR_RESET = 8'hC0;
  localparam logic [1:0] PINDIR_SERIAL = 2'h0;

  // ----------------------------------------
  // Frame sizes and timing
  // ----------------------------------------
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [1:0] SPEED_LOW_SHIFT = 2'h2;
  localparam logic [1:0] SPEED_HIGH_SHIFT = 2'h0;
  localparam logic [9:0] STOP_BIT = 10'h200;

  typedef enum logic [1:0] {
    USX_ST_IDLE = 2'b00,
    USX_ST_SHIFT = 2'b01
  } usx_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } usx_bus_t;

endpackage

// File: rtl/usx_top.sv
// Serial port transmitter with register file, baud generator and event interrupts.
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps

module usx_top #(
  parameter int DIV_W = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  output logic irq,
  input wire logic tx_clk_pin_i,
  output logic tx_clk_pin_o,
  output logic tx_clk_pin_oe_n,
  input wire logic rx_data_pin_i,
  output logic rx_data_pin_o,
  output logic rx_data_pin_oe_n
);

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  usx_pkg::usx_bus_t bus;
  logic [7:0] txsc_r;
  logic [7:0] rxsc_r;
  logic [7:0] txbuf_r;
  logic [DIV_W-1:0] baud_r;
  logic [7:0] iflag_r;
  logic [7:0] ien_r;
  logic [7:0] ipri_r;
  logic [7:0] pindir_r;
  logic [1:0] ev_stat_r;
  logic [1:0] ev_en_r;
  logic buf_full_r;
  logic [9:0] shift_r;
  logic [3:0] bits_left_r;
  usx_pkg::usx_state_t state_r;
  logic [DIV_W+1:0] tick_cnt_r;
  logic sclk_r;
  logic [1:0] clk_sync_r;
  logic [1:0] dat_sync_r;
  logic clk_prev_r;

  logic sync_mode;
  logic master;
  logic port_on;
  logic rx_active;
  logic tx_allowed;
  logic load_now;
  logic bit_tick;
  logic slave_fall;
  logic shift_step;
  logic last_bit;
  logic [DIV_W+1:0] tick_limit;
  logic [1:0] ev_set;

  assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

  function automatic logic hit(input usx_pkg::usx_bus_t b, input logic [3:0] a);
    hit = b.wr && (b.addr == a);
  endfunction

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  assign sync_mode = txsc_r[usx_pkg::TX_SYNC];
  assign master = sync_mode && txsc_r[usx_pkg::TX_CLKSRC];
  assign port_on = rxsc_r[usx_pkg::RX_SERIAL_PORT_ENABLE] &&
                   (pindir_r[7:6] == usx_pkg::PINDIR_SERIAL);
  assign rx_active = sync_mode &&
                     (rxsc_r[usx_pkg::RX_SINGLE_RECEIVE_ENABLE] || rxsc_r[usx_pkg::RX_CONTINUOUS_RECEIVE_ENABLE]);
  // Receive enables win over transmit enable in synchronous mode.
  assign tx_allowed = port_on && txsc_r[usx_pkg::TX_EN] && !rx_active;
  // Reload only at idle, so the previous last bit has gone out.
  assign load_now = tx_allowed && buf_full_r && (state_r == usx_pkg::USX_ST_IDLE);
  assign last_bit = (bits_left_r == 4'h1);

  // ----------------------------------------
  // Baud generator
  // ----------------------------------------
  // Asynchronous bit time is divisor+1 cycles at high speed and 4*divisor+1 at low speed.
  // A divisor of zero therefore gives the same one-cycle bit at both speeds.
  always_comb begin
    if (!sync_mode && !txsc_r[usx_pkg::TX_SPEED]) begin
      tick_limit = (DIV_W+2)'({2'h0, baud_r} << usx_pkg::SPEED_LOW_SHIFT);
    end else begin
      tick_limit = (DIV_W+2)'({2'h0, baud_r} << usx_pkg::SPEED_HIGH_SHIFT);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tick_cnt_r <= '0;
    end else if (clk_en) begin
      if (state_r == usx_pkg::USX_ST_IDLE || tick_cnt_r >= tick_limit) begin
        tick_cnt_r <= '0;
      end else begin
        tick_cnt_r <= tick_cnt_r + 1'b1;
      end
    end
  end

  assign bit_tick = (state_r == usx_pkg::USX_ST_SHIFT) && (tick_cnt_r >= tick_limit);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      clk_sync_r <= '0;
      dat_sync_r <= '0;
      clk_prev_r <= 1'b0;
    end else if (clk_en) begin
      clk_sync_r <= {clk_sync_r[0], tx_clk_pin_i};
      dat_sync_r <= {dat_sync_r[0], rx_data_pin_i};
      clk_prev_r <= clk_sync_r[1];
    end
  end

  // A slave shifts on the falling edge of the external clock.
  assign slave_fall = sync_mode && !master && clk_prev_r && !clk_sync_r[1];
  // In master mode a bit spans two ticks: clock low then high.
  assign shift_step = sync_mode ? (master ? (bit_tick && sclk_r) : slave_fall) : bit_tick;

  // ----------------------------------------
  // Transmit shifter
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r <= usx_pkg::USX_ST_IDLE;
      shift_r <= '0;
      bits_left_r <= '0;
      sclk_r <= 1'b0;
    end else if (clk_en) begin
      unique case (state_r)
        usx_pkg::USX_ST_IDLE: begin
          sclk_r <= 1'b0;
          if (load_now) begin
            // Asynchronous frames carry a start bit low and stop bit high.
            if (sync_mode) begin
              shift_r <= {1'b0, txsc_r[usx_pkg::TX_NINTH], txbuf_r};
            end else if (txsc_r[usx_pkg::TX_WIDTH]) begin
              shift_r <= {txsc_r[usx_pkg::TX_NINTH], txbuf_r, 1'b0};
            end else begin
              shift_r <= {1'b1, txbuf_r, 1'b0};
            end
            bits_left_r <= (txsc_r[usx_pkg::TX_WIDTH] ? usx_pkg::BITS_9 : usx_pkg::BITS_8)
                           + (sync_mode ? 4'h0 : 4'h2);
            state_r <= usx_pkg::USX_ST_SHIFT;
          end
        end
        usx_pkg::USX_ST_SHIFT: begin
          if (master && bit_tick) begin
            sclk_r <= !sclk_r;
          end
          if (!tx_allowed) begin
            state_r <= usx_pkg::USX_ST_IDLE;
            bits_left_r <= '0;
          end else if (shift_step) begin
            shift_r <= {1'b1, shift_r[9:1]};
            bits_left_r <= bits_left_r - 1'b1;
            if (last_bit) begin
              state_r <= usx_pkg::USX_ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_clk_pin_o <= 1'b1;
      tx_clk_pin_oe_n <= 1'b1;
      rx_data_pin_o <= 1'b1;
      rx_data_pin_oe_n <= 1'b1;
    end else if (clk_en) begin
      if (sync_mode) begin
        tx_clk_pin_o <= sclk_r;
        tx_clk_pin_oe_n <= !(port_on && master && !rx_active);
        rx_data_pin_o <= shift_r[0];
        rx_data_pin_oe_n <= !(tx_allowed && state_r == usx_pkg::USX_ST_SHIFT);
      end else begin
        tx_clk_pin_o <= (state_r == usx_pkg::USX_ST_SHIFT) ? shift_r[0] : 1'b1;
        tx_clk_pin_oe_n <= !(port_on && txsc_r[usx_pkg::TX_EN]);
        rx_data_pin_o <= 1'b1;
        rx_data_pin_oe_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      txsc_r <= usx_pkg::TXSC_RESET;
      rxsc_r <= usx_pkg::RXSC_RESET;
      baud_r <= '0;
      ien_r <= '0;
      ipri_r <= '0;
      ev_en_r <= '0;
      pindir_r <= usx_pkg::PINDIR_RESET;
    end else if (clk_en) begin
      // Shift-empty status is never writable.
      txsc_r[usx_pkg::TX_EMPTY] <= (state_r == usx_pkg::USX_ST_IDLE) && !load_now;
      if (hit(bus, usx_pkg::ADDR_TXSC)) begin
        txsc_r[7:4] <= bus.wdata[7:4];
        txsc_r[usx_pkg::TX_SPEED] <= bus.wdata[usx_pkg::TX_SPEED];
        txsc_r[usx_pkg::TX_NINTH] <= bus.wdata[usx_pkg::TX_NINTH];
      end
      if (hit(bus, usx_pkg::ADDR_RXSC)) begin
        rxsc_r <= bus.wdata & usx_pkg::RXSC_WMASK;
      end
      if (hit(bus, usx_pkg::ADDR_BAUD)) begin
        baud_r <= DIV_W'(bus.wdata);
      end
      if (hit(bus, usx_pkg::ADDR_IEN)) begin
        ien_r <= bus.wdata;
      end
      if (hit(bus, usx_pkg::ADDR_IPRI)) begin
        ipri_r <= bus.wdata;
      end
      if (hit(bus, usx_pkg::ADDR_IEVEN)) begin
        ev_en_r <= bus.wdata[1:0];
      end
      if (hit(bus, usx_pkg::ADDR_PINDIR)) begin
        pindir_r <= bus.wdata;
      end
    end
  end

  // ----------------------------------------
  // Transmit buffer and flag
  // ----------------------------------------
  // The flag is set when a load empties the buffer (reset leaves it clear), and a new write clears it in the same edge.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      txbuf_r <= '0;
      buf_full_r <= 1'b0;
      iflag_r <= '0;
    end else if (clk_en) begin
      if (hit(bus, usx_pkg::ADDR_TXBUF)) begin
        txbuf_r <= bus.wdata;
        buf_full_r <= 1'b1;
        iflag_r[usx_pkg::IF_TX] <= 1'b0;
      end else if (load_now) begin
        buf_full_r <= 1'b0;
        iflag_r[usx_pkg::IF_TX] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Event status and interrupt
  // ----------------------------------------
  // An aborted frame must not report completion, so the done event needs tx_allowed.
  assign ev_set = {(state_r == usx_pkg::USX_ST_SHIFT) && tx_allowed && shift_step && last_bit,
                   load_now};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ev_stat_r <= '0;
    end else if (clk_en) begin
      // A new event wins over a simultaneous clear.
      if (hit(bus, usx_pkg::ADDR_ICLR)) begin
        ev_stat_r <= (ev_stat_r & ~bus.wdata[1:0]) | ev_set;
      end else begin
        ev_stat_r <= ev_stat_r | ev_set;
      end
    end
  end

  // Only the buffer flag and event bits drive the line; shift-empty does not.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(ev_stat_r & ev_en_r) ||
             (iflag_r[usx_pkg::IF_TX] && ien_r[usx_pkg::IF_TX]);
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bus_rdata <= '0;
    end else if (clk_en) begin
      if (bus.rd) begin
        unique case (bus.addr)
          usx_pkg::ADDR_TXSC: bus_rdata <= txsc_r;
          usx_pkg::ADDR_RXSC: bus_rdata <= rxsc_r;
          usx_pkg::ADDR_TXBUF: bus_rdata <= txbuf_r;
          usx_pkg::ADDR_BAUD: bus_rdata <= 8'(baud_r);
          usx_pkg::ADDR_IFLAG: bus_rdata <= iflag_r;
          usx_pkg::ADDR_IEN: bus_rdata <= ien_r;
          usx_pkg::ADDR_IPRI: bus_rdata <= ipri_r;
          usx_pkg::ADDR_ISTAT: bus_rdata <= {6'h00, ev_stat_r};
          usx_pkg::ADDR_IEVEN: bus_rdata <= {6'h00, ev_en_r};
          usx_pkg::ADDR_PINDIR: bus_rdata <= pindir_r;
          default: bus_rdata <= 8'h00;
        endcase
      end else begin
        bus_rdata <= 8'h00;
      end
    end
  end

endmodule

// File: bench/usx_monitor.sv
// Concurrent checks on the register port and pin enables of the serial port top.
`timescale 1ns/10ps
module usx_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic irq,
  input wire logic tx_clk_pin_oe_n,
  input wire logic rx_data_pin_oe_n
);
  logic [7:0] txc_r;
  logic [7:0] rxc_r;
  logic [7:0] ien_r;
  logic [7:0] iev_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Shadow copies of written control words
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      txc_r <= 8'h00;
      rxc_r <= 8'h00;
      ien_r <= 8'h00;
      iev_r <= 8'h00;
    end else if (clk_en && bus_wr) begin
      if (bus_addr == usx_pkg::ADDR_TXSC) txc_r <= bus_wdata;
      if (bus_addr == usx_pkg::ADDR_RXSC) rxc_r <= bus_wdata;
      if (bus_addr == usx_pkg::ADDR_IEN) ien_r <= bus_wdata;
      if (bus_addr == usx_pkg::ADDR_IEVEN) iev_r <= bus_wdata;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_rd_idle; !$past(bus_rd) |-> bus_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
  property p_unmapped;
    $past(bus_rd) && $past(bus_addr) > usx_pkg::ADDR_PINDIR |-> bus_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_txsc_rb;
    $past(bus_rd) && $past(bus_addr) == usx_pkg::ADDR_TXSC
      |-> (bus_rdata & 8'hFD) == ($past(txc_r) & 8'hF5);
  endproperty
  a_txsc_rb: assert property (p_txsc_rb) else $error("control read-back wrong");
  property p_irq_off; (ien_r == 8'h00 && iev_r == 8'h00) [*2] |-> !irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with no enable");
  property p_flag_wr;
    bus_wr && bus_addr == usx_pkg::ADDR_TXBUF ##1 bus_rd && bus_addr == usx_pkg::ADDR_IFLAG
      |=> !bus_rdata[usx_pkg::IF_TX];
  endproperty
  a_flag_wr: assert property (p_flag_wr) else $error("flag not cleared by write");
  property p_dt_sync;
    !rx_data_pin_oe_n |-> txc_r[usx_pkg::TX_SYNC] || $past(txc_r[usx_pkg::TX_SYNC]);
  endproperty
  a_dt_sync: assert property (p_dt_sync) else $error("data pin driven in async");
  property p_ck_master;
    !tx_clk_pin_oe_n && txc_r[usx_pkg::TX_SYNC] && $past(txc_r[usx_pkg::TX_SYNC])
      |-> txc_r[usx_pkg::TX_CLKSRC] || $past(txc_r[usx_pkg::TX_CLKSRC]);
  endproperty
  a_ck_master: assert property (p_ck_master) else $error("clock driven as slave");
  property p_halfdup;
    (txc_r[usx_pkg::TX_SYNC] && (rxc_r[usx_pkg::RX_CONTINUOUS_RECEIVE_ENABLE] || rxc_r[usx_pkg::RX_SINGLE_RECEIVE_ENABLE])) [*2]
      |-> rx_data_pin_oe_n;
  endproperty
  a_halfdup: assert property (p_halfdup) else $error("sync send while receiving");
  property p_transmit_enable_bit_off; (!txc_r[usx_pkg::TX_EN]) [*2] |-> rx_data_pin_oe_n; endproperty
  a_transmit_enable_bit_off: assert property (p_transmit_enable_bit_off) else $error("data driven while disabled");
  c_irq: cover property (irq);
  c_sync_dt: cover property (!rx_data_pin_oe_n);
  c_master_ck: cover property (!tx_clk_pin_oe_n && txc_r[usx_pkg::TX_SYNC]);
endmodule

// File: bench/usx_peer.sv
// Behavioural serial peer: frame capture on the pins and a slave clock source.
`timescale 1ns/10ps
module usx_peer (
  input wire logic clk,
  input wire logic ck_line,
  input wire logic dt_line,
  input wire logic ck_oe_n,
  input wire logic sync_mode,
  input wire logic [7:0] bit_cyc,
  input wire logic [3:0] nbits,
  input wire logic slave_go,
  output logic ck_drv,
  output logic [8:0] word,
  output logic [8:0] prev,
  output logic stop_ok,
  output int frames,
  output logic [8:0] sword
);
  logic ck_q;
  logic [8:0] w;
  initial begin
    ck_drv = 1'b1;
    frames = 0;
    sword = 9'h000;
    ck_q = 1'b1;
  end
  // Sampling mid-bit keeps the capture clear of the edge where the line moves.
  always begin
    @(negedge ck_line);
    if (!sync_mode && !ck_oe_n) begin
      repeat (bit_cyc / 2) @(posedge clk);
      w = 9'h000;
      for (int i = 0; i < nbits; i++) begin
        repeat (bit_cyc) @(posedge clk);
        w[i] = ck_line;
      end
      repeat (bit_cyc) @(posedge clk);
      stop_ok = ck_line;
      prev = word;
      word = w;
      frames++;
    end
  end
  always @(posedge clk) begin
    ck_q <= ck_line;
    // A master frame is taken on rising clock edges, a slave frame on the falls driven here.
    if (sync_mode && (ck_oe_n ? (!ck_line && ck_q) : (ck_line && !ck_q))) begin
      sword <= {dt_line, sword[8:1]};
    end
  end
  // The slave clock idles high and gives one pulse per frame bit, so it stands still between
  // frames; each fall is the sample point here and the shift point in the port.
  always @(posedge slave_go) begin
    repeat (4) @(posedge clk);
    #1;
    repeat (nbits) begin
      ck_drv = 1'b0;
      #40;
      ck_drv = 1'b1;
      #40;
    end
  end
endmodule

// File: bench/tb.sv
// Self-checking testbench of the serial port top beside its serial peer.
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] bus_addr = 4'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata, rv, bit_cyc;
  logic irq, ck_o, ck_oe_n, dt_o, dt_oe_n, ck_drv, ck_w, dt_w, stop_ok;
  logic sync_mode = 1'b0;
  logic clk_en = 1'b1;
  logic slave_go = 1'b0;
  logic [3:0] nbits;
  logic [8:0] word, prev, sword;
  int frames;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  assign ck_w = ck_oe_n ? ck_drv : ck_o;
  assign dt_w = dt_oe_n ? 1'b1 : dt_o;
  usx_top dut_u (.clk(clk), .resetn(resetn), .clk_en(clk_en), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq),
    .tx_clk_pin_i(ck_w), .tx_clk_pin_o(ck_o), .tx_clk_pin_oe_n(ck_oe_n),
    .rx_data_pin_i(dt_w), .rx_data_pin_o(dt_o), .rx_data_pin_oe_n(dt_oe_n));
  usx_peer peer_u (.clk(clk), .ck_line(ck_w), .dt_line(dt_w), .ck_oe_n(ck_oe_n),
    .sync_mode(sync_mode), .bit_cyc(bit_cyc), .nbits(nbits), .slave_go(slave_go),
    .ck_drv(ck_drv), .word(word), .prev(prev), .stop_ok(stop_ok), .frames(frames),
    .sword(sword));
  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    rv = bus_rdata;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] exp, input string what);
    rd(a);
    chk(what, {1'b0, rv}, {1'b0, exp});
  endtask
  task automatic poll_empty();
    int t;
    t = 0;
    rd(usx_pkg::ADDR_TXSC);
    while (rv[usx_pkg::TX_EMPTY] !== 1'b1 && t < 400) begin
      rd(usx_pkg::ADDR_TXSC);
      t++;
    end
    chk("shift empty", {8'h00, rv[usx_pkg::TX_EMPTY]}, 9'h001);
  endtask
  task automatic wait_frames(input int n);
    int t;
    t = 0;
    while (frames < n && t < 2000) begin
      @(posedge clk);
      t++;
    end
    chk("frames", 9'(frames), 9'(n));
  endtask
  task automatic t_reset();
    logic [3:0] a;
    for (int i = 0; i < 12; i++) begin
      a = 4'(i);
      rd(a);
      chk("reset value", {1'b0, rv}, (a == 4'h0) ? 9'h002 : (a == 4'hA) ? 9'h0C0 : 9'h000);
    end
    wr(usx_pkg::ADDR_PINDIR, 8'h00);
    wr(usx_pkg::ADDR_RXSC, 8'h80);
  endtask
  task automatic t_async(input logic nine, input logic spd, input logic [7:0] div,
      input logic [7:0] d, input logic nb);
    logic [7:0] c;
    int f0;
    c = {nine, nine, 1'b1, 1'b0, 1'b0, spd, 1'b0, nb};
    f0 = frames;
    bit_cyc = spd ? div + 8'h01 : (div << 2) + 8'h01;
    nbits = nine ? 4'h9 : 4'h8;
    wr(usx_pkg::ADDR_BAUD, div);
    wr(usx_pkg::ADDR_TXSC, c);
    wr(usx_pkg::ADDR_TXBUF, d);
    rc(usx_pkg::ADDR_IFLAG, 8'h00, "flag after write");
    rc(usx_pkg::ADDR_IFLAG, 8'h10, "flag after load");
    rc(usx_pkg::ADDR_TXSC, c, "control busy");
    wait_frames(f0 + 1);
    chk("async word", word, {nine & nb, d});
    chk("stop bit", {8'h00, stop_ok}, 9'h001);
    poll_empty();
  endtask
  task automatic t_b2b();
    int f0;
    f0 = frames;
    wr(usx_pkg::ADDR_TXBUF, 8'h81);
    rc(usx_pkg::ADDR_IFLAG, 8'h00, "flag first");
    rc(usx_pkg::ADDR_IFLAG, 8'h10, "flag loaded");
    wr(usx_pkg::ADDR_TXBUF, 8'h7E);
    rc(usx_pkg::ADDR_IFLAG, 8'h00, "flag held");
    rc(usx_pkg::ADDR_IFLAG, 8'h00, "flag still held");
    wait_frames(f0 + 2);
    chk("first word", prev, 9'h081);
    chk("second word", word, 9'h07E);
    poll_empty();
  endtask
  task automatic t_irq();
    rc(usx_pkg::ADDR_ISTAT, 8'h03, "events");
    chk("irq off", {8'h00, irq}, 9'h000);
    wr(usx_pkg::ADDR_IEN, 8'h10);
    wr(usx_pkg::ADDR_IFLAG, 8'h00);
    rc(usx_pkg::ADDR_IFLAG, 8'h10, "flag kept");
    chk("irq flag", {8'h00, irq}, 9'h001);
    wr(usx_pkg::ADDR_IEN, 8'h00);
    wr(usx_pkg::ADDR_IEVEN, 8'h02);
    wr(usx_pkg::ADDR_ICLR, 8'h01);
    rc(usx_pkg::ADDR_ISTAT, 8'h02, "event clear");
    chk("irq event", {8'h00, irq}, 9'h001);
    wr(usx_pkg::ADDR_ICLR, 8'h02);
    rc(usx_pkg::ADDR_ISTAT, 8'h00, "events cleared");
    chk("irq cleared", {8'h00, irq}, 9'h000);
    wr(usx_pkg::ADDR_IEVEN, 8'h00);
  endtask
  task automatic t_sync();
    sync_mode = 1'b1;
    nbits = 4'h8;
    wr(usx_pkg::ADDR_RXSC, 8'h90);
    wr(usx_pkg::ADDR_BAUD, 8'h01);
    wr(usx_pkg::ADDR_TXSC, 8'hB0);
    wr(usx_pkg::ADDR_TXBUF, 8'h96);
    repeat (40) @(posedge clk);
    chk("inhibited", {8'h00, dt_oe_n}, 9'h001);
    wr(usx_pkg::ADDR_RXSC, 8'h80);
    rd(usx_pkg::ADDR_TXSC);
    rc(usx_pkg::ADDR_TXSC, 8'hB0, "sync busy");
    poll_empty();
    chk("sync word", {1'b0, sword[8:1]}, 9'h096);
    wr(usx_pkg::ADDR_TXSC, 8'h30);
    wr(usx_pkg::ADDR_TXBUF, 8'h5A);
    slave_go = 1'b1;
    rd(usx_pkg::ADDR_TXSC);
    rc(usx_pkg::ADDR_TXSC, 8'h30, "slave busy");
    poll_empty();
    chk("slave word", {1'b0, sword[8:1]}, 9'h05A);
    slave_go = 1'b0;
  endtask
  task automatic t_freeze();
    @(posedge clk);
    #1;
    clk_en <= 1'b0;
    wr(usx_pkg::ADDR_BAUD, 8'h55);
    clk_en <= 1'b1;
    rc(usx_pkg::ADDR_BAUD, 8'h01, "frozen write");
  endtask
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_async(1'b0, 1'b1, 8'h01, 8'hA5, 1'b0);
    t_async(1'b1, 1'b1, 8'h03, 8'h3C, 1'b1);
    t_async(1'b0, 1'b0, 8'h01, 8'hC3, 1'b0);
    t_b2b();
    t_irq();
    t_sync();
    t_freeze();
    conclude();
  end
endmodule
bind usx_top usx_monitor mon_u (.clk(clk), .resetn(resetn), .clk_en(clk_en),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .irq(irq), .tx_clk_pin_oe_n(tx_clk_pin_oe_n),
  .rx_data_pin_oe_n(rx_data_pin_oe_n));
